// ==== common/lpvm_pkg.sv ====
// Purpose: shared constants for the low-power mode and voltage monitor block
// Assumes: one 25 MHz clock, software controls as plain same-clock ports
// Notes:   mode codes are Gray along run, clock stop, standby
package lpvm_pkg;

  localparam int unsigned MON_CNT      = 2;
  localparam int unsigned SYNC_W       = 4;
  localparam int unsigned SYNC_MON_ONE = 0;
  localparam int unsigned SYNC_MON_TWO = 1;
  localparam int unsigned SYNC_CLK_ACK = 2;
  localparam int unsigned SYNC_STRAP   = 3;

  localparam int unsigned UNIT_CNT     = 3;
  localparam int unsigned UNIT_XFER    = 0;
  localparam int unsigned UNIT_ADC     = 1;
  localparam int unsigned UNIT_SERIAL  = 2;

  localparam logic [3:0] LEVEL_ONE_MAX   = 4'h8;
  localparam logic [3:0] LEVEL_ONE_RESET = 4'h0;
  localparam logic [1:0] LEVEL_TWO_RESET = 2'h0;

  localparam logic [2:0] STRAP_SETTLE    = 3'h6;

  localparam int unsigned EDGE_FALL = 0;
  localparam int unsigned EDGE_RISE = 1;

  localparam logic [1:0] REQ_SLEEP   = 2'h0;
  localparam logic [1:0] REQ_DEEP    = 2'h1;
  localparam logic [1:0] REQ_STANDBY = 2'h2;

  typedef enum logic [2:0] {
    LPVM_RUN      = 3'h0,
    LPVM_CLK_STOP = 3'h1,
    LPVM_STANDBY  = 3'h3,
    LPVM_SLEEP    = 3'h4,
    LPVM_DEEP     = 3'h6
  } lpvm_mode_t;

endpackage : lpvm_pkg

// ==== rtl/lpvm_sync.sv ====
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs asynchronous to core_clk_i
// Notes:   output follows once stages two and three agree
`timescale 1ns/1ns
module lpvm_sync
  import lpvm_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  input  wire logic [SYNC_W-1:0] async_i,
  output logic      [SYNC_W-1:0] stable_o
);

  logic [SYNC_W-1:0] stage_one;
  logic [SYNC_W-1:0] stage_two;
  logic [SYNC_W-1:0] stage_three;
  logic [SYNC_W-1:0] next_stable;

  always_comb
  begin
    next_stable = stable_o;
    for (int i = 0; i < SYNC_W; i++)
    begin
      if (stage_two[i] == stage_three[i])
      begin
        next_stable[i] = stage_three[i];
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stage_one   <= '0;
      stage_two   <= '0;
      stage_three <= '0;
      stable_o    <= '0;
    end
    else
    begin
      stage_one   <= async_i;
      stage_two   <= stage_one;
      stage_three <= stage_two;
      stable_o    <= next_stable;
    end
  end

endmodule : lpvm_sync

// ==== rtl/lpvm_top.sv ====
// Purpose: low-power mode control, watchdog count halt and two voltage monitors
// Assumes: comparator outputs, clock stop ack and strap are asynchronous pins
// Notes:   detection flags are cleared only by rst_i or software clear
`timescale 1ns/1ns
// Notes on behaviour
// - retained units keep settings while suspended and resume from them on wake.
// - in autostart mode the option word bit decides watchdog halt in sleep.
// - otherwise the count halt control bit decides watchdog halt in sleep.
// - main clock stops before standby; oscillation stop detection then unavailable.
// - sleep and deep sleep keep unit clocks unless module stop is set.
// - clock monitoring runs in sleep and deep sleep.
// - monitor one threshold from four-bit field, nine valid codes.
// - monitor two threshold from two-bit field, four codes.
// - interrupt mode raises request on falling, rising or both crossings.
// - both monitors keep working in every low-power mode.
// - each monitor sets its own detection flag on detection.
// - monitor or watchdog interrupt wakes the device from standby.
module lpvm_top
  import lpvm_pkg::*;
(
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  enter_lp_i,
  input  wire logic [1:0]            lp_select_i,
  input  wire logic                  wake_irq_i,
  input  wire logic                  wdt_irq_i,
  input  wire logic                  main_clk_stop_ack_i,
  input  wire logic                  autostart_strap_i,
  input  wire logic                  autostart_sleep_count_halt_i,
  input  wire logic                  sleep_count_halt_bit_i,
  input  wire logic [UNIT_CNT-1:0]   module_stop_i,
  input  wire logic [3:0]            monitor_one_level_field_i,
  input  wire logic [1:0]            monitor_two_level_field_i,
  input  wire logic [MON_CNT-1:0]    mon_enable_i,
  input  wire logic [MON_CNT-1:0]    mon_reset_mode_i,
  input  wire logic [2*MON_CNT-1:0]  mon_edge_sel_i,
  input  wire logic [MON_CNT-1:0]    mon_flag_clr_i,
  input  wire logic                  below_one_i,
  input  wire logic                  below_two_i,
  output logic      [2:0]            lp_mode_o,
  output logic                       cpu_clk_en_o,
  output logic [UNIT_CNT-1:0]        unit_clk_en_o,
  output logic                       main_clk_stop_req_o,
  output logic                       osc_stop_det_en_o,
  output logic                       sysctl_wr_lock_o,
  output logic                       wdt_count_en_o,
  output logic                       autostart_o,
  output logic      [3:0]            threshold_one_o,
  output logic      [1:0]            threshold_two_o,
  output logic [MON_CNT-1:0]         mon_irq_o,
  output logic [MON_CNT-1:0]         mon_reset_o,
  output logic [MON_CNT-1:0]         mon_flag_o
);

  lpvm_mode_t          mode;
  lpvm_mode_t          next_mode;
  logic [SYNC_W-1:0]   pin_raw;
  logic [SYNC_W-1:0]   pin_stable;
  logic [MON_CNT-1:0]  below;
  logic [MON_CNT-1:0]  below_prev;
  logic [MON_CNT-1:0]  irq_evt;
  logic [MON_CNT-1:0]  reset_lvl;
  logic [MON_CNT-1:0]  next_flag;
  logic [2:0]          strap_cnt;
  logic [2:0]          next_strap_cnt;
  logic                next_autostart;
  logic                clk_ack;
  logic                wake_standby;
  logic                wake_sleep;
  logic                halt_sel;
  logic [2:0]          next_lp_mode;
  logic                next_cpu_clk_en;
  logic [UNIT_CNT-1:0] next_unit_clk_en;
  logic                next_clk_stop_req;
  logic                next_osc_det_en;
  logic                next_wr_lock;
  logic                next_wdt_en;
  logic [3:0]          next_thr_one;
  logic [1:0]          next_thr_two;

  assign pin_raw[SYNC_MON_ONE] = below_one_i;
  assign pin_raw[SYNC_MON_TWO] = below_two_i;
  assign pin_raw[SYNC_CLK_ACK] = main_clk_stop_ack_i;
  assign pin_raw[SYNC_STRAP]   = autostart_strap_i;

  lpvm_sync u_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    (pin_raw),
    .stable_o   (pin_stable)
  );

  assign below[0] = pin_stable[SYNC_MON_ONE];
  assign below[1] = pin_stable[SYNC_MON_TWO];
  assign clk_ack  = pin_stable[SYNC_CLK_ACK];

  // per-channel detection, runs regardless of mode
  genvar ch;
  generate
    for (ch = 0; ch < MON_CNT; ch++)
    begin : g_mon
      logic fall;
      logic rise;
      assign fall = below[ch] & ~below_prev[ch];
      assign rise = ~below[ch] & below_prev[ch];
      assign irq_evt[ch] = mon_enable_i[ch] & ~mon_reset_mode_i[ch]
                         & ((fall & mon_edge_sel_i[2*ch+EDGE_FALL])
                          | (rise & mon_edge_sel_i[2*ch+EDGE_RISE]));
      assign reset_lvl[ch] = mon_enable_i[ch] & mon_reset_mode_i[ch]
                           & below[ch];
      assign next_flag[ch] = (mon_flag_o[ch] & ~mon_flag_clr_i[ch])
                           | irq_evt[ch] | reset_lvl[ch];
    end
  endgenerate

  assign wake_standby = (|irq_evt) | wdt_irq_i;
  assign wake_sleep   = wake_standby | wake_irq_i;

  always_comb
  begin
    next_mode = mode;
    unique case (mode)
      LPVM_RUN:
      begin
        if (enter_lp_i)
        begin
          if (lp_select_i == REQ_SLEEP)
          begin
            next_mode = LPVM_SLEEP;
          end
          else if (lp_select_i == REQ_DEEP)
          begin
            next_mode = LPVM_DEEP;
          end
          else if (lp_select_i == REQ_STANDBY)
          begin
            next_mode = LPVM_CLK_STOP;
          end
        end
      end
      LPVM_SLEEP, LPVM_DEEP:
      begin
        if (wake_sleep || (|reset_lvl))
        begin
          next_mode = LPVM_RUN;
        end
      end
      LPVM_CLK_STOP:
      begin
        if (wake_standby || (|reset_lvl))
        begin
          next_mode = LPVM_RUN;
        end
        else if (clk_ack)
        begin
          next_mode = LPVM_STANDBY;
        end
      end
      LPVM_STANDBY:
      begin
        if (wake_standby || (|reset_lvl))
        begin
          next_mode = LPVM_RUN;
        end
      end
      default:
      begin
        next_mode = LPVM_RUN;
      end
    endcase
  end

  always_comb
  begin
    next_lp_mode      = next_mode;
    next_cpu_clk_en   = (next_mode == LPVM_RUN);
    next_clk_stop_req = (next_mode == LPVM_CLK_STOP)
                      || (next_mode == LPVM_STANDBY);
    next_osc_det_en   = !next_clk_stop_req;
    next_wr_lock      = (next_mode == LPVM_SLEEP);
    // halt bit source follows the captured strap
    if (autostart_o)
    begin
      halt_sel = autostart_sleep_count_halt_i;
    end
    else
    begin
      halt_sel = sleep_count_halt_bit_i;
    end
    next_wdt_en = !((next_mode != LPVM_RUN) && halt_sel);
  end

  // standby gates all units, settings held by their own flops
  genvar un;
  generate
    for (un = 0; un < UNIT_CNT; un++)
    begin : g_unit
      assign next_unit_clk_en[un] = !module_stop_i[un] && !next_clk_stop_req;
    end
  endgenerate

  // invalid level-one codes keep the last applied threshold
  always_comb
  begin
    next_thr_one = threshold_one_o;
    if (monitor_one_level_field_i <= LEVEL_ONE_MAX)
    begin
      next_thr_one = monitor_one_level_field_i;
    end
    next_thr_two = monitor_two_level_field_i;
  end

  // strap read on each of the first six cycles after reset, the sixth read kept
  always_comb
  begin
    next_strap_cnt = strap_cnt;
    next_autostart = autostart_o;
    if (strap_cnt != STRAP_SETTLE)
    begin
      next_strap_cnt = strap_cnt + 3'h1;
      next_autostart = pin_stable[SYNC_STRAP];
    end
  end

  // mode and clock control
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode                <= LPVM_RUN;
      lp_mode_o           <= LPVM_RUN;
      cpu_clk_en_o        <= 1'b1;
      unit_clk_en_o       <= '0;
      main_clk_stop_req_o <= 1'b0;
      osc_stop_det_en_o   <= 1'b1;
      sysctl_wr_lock_o    <= 1'b0;
      wdt_count_en_o      <= 1'b1;
    end
    else
    begin
      mode                <= next_mode;
      lp_mode_o           <= next_lp_mode;
      cpu_clk_en_o        <= next_cpu_clk_en;
      unit_clk_en_o       <= next_unit_clk_en;
      main_clk_stop_req_o <= next_clk_stop_req;
      osc_stop_det_en_o   <= next_osc_det_en;
      sysctl_wr_lock_o    <= next_wr_lock;
      wdt_count_en_o      <= next_wdt_en;
    end
  end

  // autostart captured once after reset
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      autostart_o         <= 1'b0;
      strap_cnt           <= '0;
    end
    else
    begin
      autostart_o         <= next_autostart;
      strap_cnt           <= next_strap_cnt;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      threshold_one_o     <= LEVEL_ONE_RESET;
      threshold_two_o     <= LEVEL_TWO_RESET;
    end
    else
    begin
      threshold_one_o     <= next_thr_one;
      threshold_two_o     <= next_thr_two;
    end
  end

  // flags cleared only by rst_i or software, never by a monitor reset
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      below_prev          <= '0;
      mon_irq_o           <= '0;
      mon_reset_o         <= '0;
      mon_flag_o          <= '0;
    end
    else
    begin
      below_prev          <= below;
      mon_irq_o           <= irq_evt;
      mon_reset_o         <= reset_lvl;
      mon_flag_o          <= next_flag;
    end
  end

endmodule : lpvm_top

// ==== tb/lpvm_top_asserts.sv ====
// Purpose: port-level checks for lpvm_top
// Assumes: one clock, async active-high reset
// Notes:   bound to every lpvm_top instance
`timescale 1ns/1ns
module lpvm_top_asserts
  import lpvm_pkg::*;
(
  input wire logic                         core_clk_i,
  input wire logic                         rst_i,
  input wire logic [lpvm_pkg::UNIT_CNT-1:0] module_stop_i,
  input wire logic                         autostart_sleep_count_halt_i,
  input wire logic                         sleep_count_halt_bit_i,
  input wire logic [1:0]                   mon_enable_i,
  input wire logic [1:0]                   mon_reset_mode_i,
  input wire logic [1:0]                   mon_flag_clr_i,
  input wire logic [2:0]                   lp_mode_o,
  input wire logic [lpvm_pkg::UNIT_CNT-1:0] unit_clk_en_o,
  input wire logic                         main_clk_stop_req_o,
  input wire logic                         osc_stop_det_en_o,
  input wire logic                         sysctl_wr_lock_o,
  input wire logic                         wdt_count_en_o,
  input wire logic                         autostart_o,
  input wire logic [3:0]                   threshold_one_o,
  input wire logic [1:0]                   mon_irq_o,
  input wire logic [1:0]                   mon_reset_o,
  input wire logic [1:0]                   mon_flag_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic h;
  assign h = autostart_o ? autostart_sleep_count_halt_i : sleep_count_halt_bit_i;
  sequence s_after_irq;
    !mon_irq_o[0];
  endsequence
  a_lock_sleep: assert property (sysctl_wr_lock_o == (lp_mode_o == LPVM_SLEEP))
    else $error("write lock not tied to sleep");
  a_osc_det_off: assert property (osc_stop_det_en_o != main_clk_stop_req_o)
    else $error("osc stop detect enable wrong");
  a_stop_req_mode: assert property
    (main_clk_stop_req_o == (lp_mode_o inside {LPVM_CLK_STOP, LPVM_STANDBY}))
    else $error("main clock stop request wrong");
  a_unit_gate: assert property ((lp_mode_o inside {LPVM_SLEEP, LPVM_DEEP}) &&
    $stable(module_stop_i) && $stable(lp_mode_o) |-> unit_clk_en_o == ~module_stop_i)
    else $error("unit clock gate wrong");
  a_wdt_halt: assert property ($stable(lp_mode_o) && $stable(h) |->
    wdt_count_en_o == !(lp_mode_o != LPVM_RUN && h))
    else $error("watchdog count enable wrong");
  a_thr_valid: assert property (threshold_one_o <= LEVEL_ONE_MAX)
    else $error("invalid level one applied");
  a_irq_pulse: assert property (mon_irq_o[0] |-> mon_flag_o[0] ##1 s_after_irq)
    else $error("irq not one cycle or flag not set");
  a_flag_hold: assert property (mon_flag_o[1] && !mon_flag_clr_i[1] |=> mon_flag_o[1])
    else $error("flag dropped without clear");
  a_reset_cause: assert property (mon_reset_o[0] |->
    $past(mon_enable_i[0]) && $past(mon_reset_mode_i[0]))
    else $error("monitor reset without reset mode");
  a_irq_cause: assert property (mon_irq_o[1] |->
    $past(mon_enable_i[1]) && !$past(mon_reset_mode_i[1]))
    else $error("monitor irq without irq mode");
endmodule : lpvm_top_asserts

bind lpvm_top lpvm_top_asserts i_chk (.*);

// ==== tb/tb.sv ====
// Purpose: self-checking bench for lpvm_top
// Assumes: inputs change at the falling clock edge
// Notes:   expectations from a small mode and monitor model
`timescale 1ns/1ns
module tb;
  import lpvm_pkg::*;
  logic core_clk_i = 0, rst_i = 1, enter_lp_i = 0, wake_irq_i = 0, wdt_irq_i = 0;
  logic main_clk_stop_ack_i = 0, autostart_strap_i = 0, below_one_i = 0, below_two_i = 0;
  logic autostart_sleep_count_halt_i = 0, sleep_count_halt_bit_i = 0, strap;
  logic [1:0] lp_select_i = 0, monitor_two_level_field_i = 0, mon_enable_i = 0;
  logic [1:0] mon_reset_mode_i = 0, mon_flag_clr_i = 0;
  logic [1:0] threshold_two_o, mon_irq_o, mon_reset_o, mon_flag_o;
  logic [2:0] module_stop_i = 0, lp_mode_o, unit_clk_en_o;
  logic [3:0] monitor_one_level_field_i = 0, mon_edge_sel_i = 0, threshold_one_o;
  logic cpu_clk_en_o, main_clk_stop_req_o, osc_stop_det_en_o, sysctl_wr_lock_o;
  logic wdt_count_en_o, autostart_o;
  int mismatches = 0, total_checks = 0, cyc = 0, p, prev;
  integer seed = 32'hCCDB9746;
  lpvm_top i_dut (.*);
  always #20 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      close_out();
    end
  end
  task close_out;
    if (mismatches == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [7:0] s, input int e);
    total_checks++;
    if (s !== 8'(e))
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, 8'(e), s);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : tick
  task automatic pulse(input bit w);
    if (w)
      wdt_irq_i = 1;
    else
      wake_irq_i = 1;
    tick(1);
    wdt_irq_i = 0;
    wake_irq_i = 0;
    tick(2);
  endtask : pulse
  task automatic enter(input int sel);
    lp_select_i = 2'(sel);
    enter_lp_i = 1;
    tick(1);
    enter_lp_i = 0;
    module_stop_i = 3'($random(seed));
    tick(2);
  endtask : enter
  task automatic exp_mode(input logic [2:0] m);
    logic h;
    logic sr;
    h = strap ? autostart_sleep_count_halt_i : sleep_count_halt_bit_i;
    sr = (m == LPVM_CLK_STOP) || (m == LPVM_STANDBY);
    chk("mode", lp_mode_o, m);
    chk("ctl", {cpu_clk_en_o, main_clk_stop_req_o, osc_stop_det_en_o, sysctl_wr_lock_o,
        wdt_count_en_o, unit_clk_en_o}, {m == LPVM_RUN, sr, !sr, m == LPVM_SLEEP,
        !(m != LPVM_RUN && h), sr ? 3'h0 : ~module_stop_i});
    chk("thr_kept", {threshold_one_o, threshold_two_o}, {prev[3:0], 2'h3});
  endtask : exp_mode
  task automatic set_below(input int ch, input logic v);
    if (ch == 0)
      below_one_i = v;
    else
      below_two_i = v;
  endtask : set_below
  task automatic watch(input int ch);
    p = 0;
    repeat (10)
    begin
      tick(1);
      p += int'(mon_irq_o[ch] === 1'b1);
    end
  endtask : watch
  initial
  begin
    for (int s = 0; s < 2; s++)
    begin
      strap = s[0];
      rst_i = 1;
      autostart_strap_i = strap;
      tick(16);
      chk("rst", {lp_mode_o, cpu_clk_en_o, main_clk_stop_req_o, osc_stop_det_en_o,
          sysctl_wr_lock_o, wdt_count_en_o}, 8'h15);
      chk("rst_mon", {threshold_one_o, mon_flag_o, mon_reset_o}, 0);
      rst_i = 0;
      tick(12);
      chk("autostart", autostart_o, strap);
      prev = 0;
      for (int k = 0; k < 16; k++)
      begin
        monitor_one_level_field_i = 4'(k);
        monitor_two_level_field_i = 2'(k);
        tick(2);
        if (k <= 8)
          prev = k;
        chk("thr_one", threshold_one_o, prev);
        chk("thr_two", threshold_two_o, k % 4);
      end
      repeat (4)
      begin
        sleep_count_halt_bit_i = 1'($random(seed));
        autostart_sleep_count_halt_i = 1'($random(seed));
        for (int sel = 0; sel < 4; sel++)
        begin
          enter(sel);
          if (sel == 3)
            exp_mode(LPVM_RUN);
          else if (sel == 2)
          begin
            exp_mode(LPVM_CLK_STOP);
            main_clk_stop_ack_i = 1;
            tick(8);
            exp_mode(LPVM_STANDBY);
            pulse(0);
            exp_mode(LPVM_STANDBY);
            pulse(1);
            exp_mode(LPVM_RUN);
            main_clk_stop_ack_i = 0;
            tick(8);
          end
          else
          begin
            exp_mode(sel ? LPVM_DEEP : LPVM_SLEEP);
            pulse(sel[0]);
            exp_mode(LPVM_RUN);
          end
        end
      end
      main_clk_stop_ack_i = 1;
      for (int ch = 0; ch < 2; ch++)
      begin
        for (int e = 1; e < 4; e++)
        begin
          mon_edge_sel_i = 4'(e << (2 * ch));
          mon_enable_i = 2'(1 << ch);
          mon_reset_mode_i = 0;
          enter(e - 1);
          tick(6);
          set_below(ch, 1);
          watch(ch);
          chk("irq_fall", 8'(p), e & 1);
          chk("wake_mon", lp_mode_o, (e & 1) ? 0 : LPVM_DEEP);
          chk("flag_fall", mon_flag_o, (e & 1) << ch);
          if (e == 2)
            pulse(1);
          set_below(ch, 0);
          watch(ch);
          chk("irq_rise", 8'(p), e >> 1);
          chk("flag_any", mon_flag_o, 1 << ch);
          mon_flag_clr_i = 2'h3;
          tick(1);
          mon_flag_clr_i = 0;
          tick(2);
          chk("flag_clr", mon_flag_o, 0);
        end
        mon_reset_mode_i = 2'h3;
        mon_enable_i = 2'h3;
        set_below(ch, 1);
        watch(ch);
        chk("rst_irq", 8'(p), 0);
        chk("rst_lvl", mon_reset_o, 1 << ch);
        mon_flag_clr_i = 2'h3;
        tick(1);
        mon_flag_clr_i = 0;
        tick(1);
        chk("rst_flag", mon_flag_o, 1 << ch);
        set_below(ch, 0);
        tick(8);
        chk("rst_rel", {mon_reset_o, mon_flag_o}, 1 << ch);
        mon_enable_i = 0;
        mon_flag_clr_i = 2'h3;
        tick(1);
        mon_flag_clr_i = 0;
        tick(2);
        chk("rst_clr", mon_flag_o, 0);
      end
      main_clk_stop_ack_i = 0;
    end
    close_out();
  end
endmodule : tb
